// ==== verilog/sbs_port.sv ====
// synchronous flow-through burst sram port with array, burst counter and io control
`timescale 1ns/10ps
module sbs_port
  import sbs_pkg::*;
#(
  parameter int ADDR_BITS = sbs_pkg::ADDR_W
) (
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      clk_en_in,
  input  wire logic [sbs_pkg::ADDR_W-1:0] addr_in,
  input  wire logic                      controller_addr_strobe_n_in,
  input  wire logic                      processor_addr_strobe_n_in,
  input  wire logic                      chip_select_primary_n_in,
  input  wire logic                      burst_step_n_in,
  input  wire logic [sbs_pkg::BYTES-1:0] byte_write_select_n_in,
  input  wire logic                      byte_write_global_en_n_in,
  input  wire logic                      all_bytes_write_n_in,
  input  wire logic                      output_enable_n_in,
  input  wire logic                      sleep_request_in,
  input  wire logic                      burst_order_in,
  input  wire logic [sbs_pkg::DATA_W-1:0] data_in,
  input  wire logic [sbs_pkg::BYTES-1:0] parity_lines_in,
  output logic      [sbs_pkg::DATA_W-1:0] data_out,
  output logic      [sbs_pkg::BYTES-1:0] parity_lines_out,
  output logic                           data_oe_out,
  output logic                           sleep_active_out,
  output logic                           write_busy_out
);
  import sbs_pkg::*;

  initial begin
    if (ADDR_BITS != ADDR_W) $error("sbs_port address width must match the package");
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers for the asynchronous pins
  logic oe_n_s1, oe_n_s2;                  // output enable sync pair
  logic zz_s1, zz_s2;                      // sleep sync pair
  logic mode_s1, mode_s2;                  // burst order strap sync pair

  // two flops per asynchronous pin
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      oe_n_s1 <= 1'b1;
      oe_n_s2 <= 1'b1;
      zz_s1   <= 1'b0;
      zz_s2   <= 1'b0;
      mode_s1 <= 1'b1;
      mode_s2 <= 1'b1;
    end else if (clk_en_in) begin
      oe_n_s1 <= output_enable_n_in;
      oe_n_s2 <= oe_n_s1;
      zz_s1   <= sleep_request_in;
      zz_s2   <= zz_s1;
      mode_s1 <= burst_order_in;
      mode_s2 <= mode_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // burst address generation

  // next burst low bits for either order
  function automatic logic [BURST_W-1:0] burst_addr(input logic interleave,
                                                    input logic [BURST_W-1:0] base,
                                                    input logic [BURST_W-1:0] cnt);
    burst_addr = interleave ? (base ^ cnt) : BURST_W'(base + cnt);
  endfunction

  logic [ADDR_W-1:0]  base_addr;           // captured start address
  logic [BURST_W-1:0] burst_cnt;           // steps taken in the burst
  logic               selected;            // device currently selected
  logic               first_clk;           // first clock after deselect
  sbs_cyc_t           cyc;                 // current cycle type
  logic [ADDR_W-1:0]  next_base_addr;
  logic [BURST_W-1:0] next_burst_cnt;
  logic               next_selected;
  logic               next_first_clk;
  sbs_cyc_t           next_cyc;
  logic               proc_start;          // processor strobe accepted
  logic               ctrl_start;          // controller strobe accepted
  logic               is_write;            // a write is requested this edge
  logic [BYTES-1:0]   wr_bytes;            // byte lanes written
  logic [ADDR_W-1:0]  cur_addr;            // address seen this edge

  // strobe priority, counter load and advance
  always_comb begin
    proc_start = !processor_addr_strobe_n_in && !chip_select_primary_n_in;
    ctrl_start = !controller_addr_strobe_n_in && !proc_start;
    is_write   = !all_bytes_write_n_in ||
                 (!byte_write_global_en_n_in && (byte_write_select_n_in != '1));
    wr_bytes   = !all_bytes_write_n_in ? '1 :
                 (!byte_write_global_en_n_in ? ~byte_write_select_n_in : '0);
    next_base_addr = base_addr;
    next_burst_cnt = burst_cnt;
    next_selected  = selected;
    next_cyc       = cyc;
    if (zz_s2) begin
      next_cyc = SBS_IDLE;
    end else if (proc_start || ctrl_start) begin
      next_base_addr = addr_in;
      next_burst_cnt = '0;
      next_selected  = !chip_select_primary_n_in;
      next_cyc       = chip_select_primary_n_in ? SBS_IDLE :
                       ((ctrl_start && is_write) ? SBS_WRITE : SBS_READ);
    end else if (selected) begin
      if (!burst_step_n_in) begin
        next_burst_cnt = BURST_W'(burst_cnt + BURST_ONE);
      end
      next_cyc = is_write ? SBS_WRITE : SBS_READ;
    end
    next_first_clk = next_selected && !selected;
    cur_addr = {next_base_addr[ADDR_W-1:BURST_W],
                burst_addr(mode_s2, next_base_addr[BURST_W-1:0], next_burst_cnt)};
  end

  // register the address state
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      base_addr <= '0;
      burst_cnt <= '0;
      selected  <= 1'b0;
      first_clk <= 1'b0;
      cyc       <= SBS_IDLE;
    end else if (clk_en_in) begin
      base_addr <= next_base_addr;
      burst_cnt <= next_burst_cnt;
      selected  <= next_selected;
      first_clk <= next_first_clk;
      cyc       <= next_cyc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // posted write path through the fifo, and the array
  logic [DATA_W-1:0] mem [2**ADDR_W];      // data array
  logic [BYTES-1:0]  pmem [2**ADDR_W];     // parity array
  sbs_wr_t           wr_word;              // registered input word
  logic              wr_valid;             // captured word waiting to enter fifo
  logic              fifo_ready;
  logic              fifo_valid;
  sbs_wr_t           fifo_word;
  logic              drain;                // array accepts a word
  sbs_wr_t           next_wr_word;
  logic              next_wr_valid;

  // capture data lines on a write edge
  always_comb begin
    next_wr_word  = wr_word;
    next_wr_valid = wr_valid && !fifo_ready;
    if (!zz_s2 && next_cyc == SBS_WRITE && next_selected && wr_bytes != '0) begin
      next_wr_word.addr = cur_addr;
      next_wr_word.be   = wr_bytes;
      next_wr_word.data = data_in;
      next_wr_word.par  = parity_lines_in;
      next_wr_valid     = 1'b1;
    end
    drain = fifo_valid && !zz_s2;
  end

  sbs_fifo #(
    .WIDTH (WR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .clk_en_in     (clk_en_in),
    .in_valid_in   (wr_valid),
    .in_ready_out  (fifo_ready),
    .in_data_in    (wr_word),
    .out_valid_out (fifo_valid),
    .out_ready_in  (drain),
    .out_data_out  (fifo_word)
  );

  logic [DATA_W-1:0] rd_data;              // read word straight from the array; pending fifo writes are not merged
  logic [BYTES-1:0]  rd_par;

  // register capture and drain words into the array byte by byte
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      wr_word  <= '0;
      wr_valid <= 1'b0;
    end else if (clk_en_in) begin
      wr_word  <= next_wr_word;
      wr_valid <= next_wr_valid;
      for (int b = 0; b < BYTES; b++) begin
        if (drain && fifo_word.be[b]) begin
          mem[fifo_word.addr][b*BYTE_W +: BYTE_W] <= fifo_word.data[b*BYTE_W +: BYTE_W];
          pmem[fifo_word.addr][b] <= fifo_word.par[b];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and output drive
  logic              next_oe;

  // read word from the address of this edge; drive enable rules
  always_comb begin
    rd_data = mem[cur_addr];
    rd_par  = pmem[cur_addr];
    next_oe = !oe_n_s2 && next_selected && !next_first_clk &&
              next_cyc == SBS_READ && !zz_s2;
  end

  // outputs straight from flops
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      data_out         <= '0;
      parity_lines_out <= '0;
      data_oe_out      <= 1'b0;
      sleep_active_out <= 1'b0;
      write_busy_out   <= 1'b0;
    end else if (clk_en_in) begin
      if (next_cyc == SBS_READ) begin
        data_out         <= rd_data;
        parity_lines_out <= rd_par;
      end
      data_oe_out      <= next_oe;
      sleep_active_out <= zz_s2;
      write_busy_out   <= !fifo_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_deselect_float: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && !next_selected) |=> !data_oe_out) else $error("drive while deselected");
  chk_first_clk: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && next_first_clk) |=> !data_oe_out) else $error("drive on first clock");
  chk_oe_high: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && oe_n_s2) |=> !data_oe_out) else $error("drive with enable high");
  chk_strobe_prio: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && !zz_s2 && proc_start) |=> (cyc == SBS_READ)) else $error("priority lost");
  chk_addr_load: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && !zz_s2 && !controller_addr_strobe_n_in)
    |=> (base_addr == $past(addr_in) && burst_cnt == '0)) else $error("address not captured");
  chk_burst_step: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && !zz_s2 && selected && !proc_start && !ctrl_start && !burst_step_n_in)
    |=> burst_cnt == BURST_W'($past(burst_cnt) + BURST_ONE)) else $error("no advance");
  chk_all_bytes: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (!all_bytes_write_n_in) |-> wr_bytes == '1) else $error("not all bytes");
  chk_sleep_idle: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && zz_s2) |=> (!data_oe_out && sleep_active_out)) else $error("active in sleep");
  cov_read: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) data_oe_out);
  cov_fifo_full: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) write_busy_out);
  cov_sleep: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) sleep_active_out);
endmodule

// ==== inc/sbs_pkg.sv ====
// package for the synchronous burst sram port: widths, encodings and carriers
package sbs_pkg;
  localparam int ADDR_W     = 10;          // word address width of the array model
  localparam int BYTES      = 2;           // byte lanes
  localparam int BYTE_W     = 8;           // data bits per lane
  localparam int DATA_W     = BYTES * BYTE_W;
  localparam int BURST_W    = 2;           // burst counter width
  localparam int FIFO_DEPTH = 8;           // write data fifo depth
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;

  // one word with its parity bits and byte enables
  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    logic [BYTES-1:0]   be;
    logic [BYTES-1:0]   par;
    logic [DATA_W-1:0]  data;
  } sbs_wr_t;

  localparam int WR_W = $bits(sbs_wr_t);

  // cycle type decoded from the strobes
  typedef enum logic [1:0] {
    SBS_IDLE,
    SBS_READ,
    SBS_WRITE
  } sbs_cyc_t;
endpackage

// ==== verilog/sbs_fifo.sv ====
// parameterised valid/ready fifo holding posted write words
`timescale 1ns/10ps
module sbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             clk_en_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) $error("sbs_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];           // storage words
  logic [PW:0]      wr_ptr;                // write pointer with wrap bit
  logic [PW:0]      rd_ptr;                // read pointer with wrap bit
  logic [PW:0]      next_wr_ptr;
  logic [PW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  // pointer next values
  always_comb begin
    push        = in_valid_in && in_ready_out;
    pop         = out_valid_out && out_ready_in;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  // register pointers and storage
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (clk_en_in) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      if (push) begin
        mem[wr_ptr[PW-1:0]] <= in_data_in;
      end
    end
  end

  // honest full and empty flags
  assign in_ready_out  = !((wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]));
  assign out_valid_out = (wr_ptr != rd_ptr);
  assign out_data_out  = mem[rd_ptr[PW-1:0]];
endmodule

// ==== tb/sbs_host_model.sv ====
// controller-side model of the synchronous sram bus with its async and strap pins
`timescale 1ns/10ps
module sbs_host_model (
  input  wire logic                       sys_clk_in,
  output logic      [sbs_pkg::ADDR_W-1:0] addr_out,
  output logic                            controller_addr_strobe_n_out,
  output logic                            processor_addr_strobe_n_out,
  output logic                            chip_select_primary_n_out,
  output logic                            burst_step_n_out,
  output logic      [sbs_pkg::BYTES-1:0]  byte_write_select_n_out,
  output logic                            byte_write_global_en_n_out,
  output logic                            all_bytes_write_n_out,
  output logic                            output_enable_n_out,
  output logic                            sleep_request_out,
  output logic                            burst_order_out,
  output logic      [sbs_pkg::DATA_W-1:0] data_out,
  output logic      [sbs_pkg::BYTES-1:0]  parity_lines_out
);
  import sbs_pkg::*;
  //////////////////////////////////////////////////////////////
  // quiet bus at time zero: no strobes, selected, sleep low, interleaved strap
  initial begin
    {controller_addr_strobe_n_out, processor_addr_strobe_n_out, burst_step_n_out} = 3'h7;
    chip_select_primary_n_out = 1'b0;
    {byte_write_select_n_out, byte_write_global_en_n_out, all_bytes_write_n_out} = 4'hF;
    addr_out = '0;
    {parity_lines_out, data_out} = '0;
    output_enable_n_out = 1'b0;
    sleep_request_out = 1'b0;
    burst_order_out = 1'b1;
  end
  //////////////////////////////////////////////////////////////
  // one bus cycle: signals change just after an edge and stand until the next edge
  task automatic bus_cycle(input logic cs_n, input logic ctl_n, input logic prc_n,
                           input logic step_n, input logic gw_n, input logic bwe_n,
                           input logic [BYTES-1:0] bw_n, input logic [ADDR_W-1:0] a,
                           input logic [BYTES+DATA_W-1:0] wd);
    chip_select_primary_n_out = cs_n;
    controller_addr_strobe_n_out = ctl_n;
    processor_addr_strobe_n_out = prc_n;
    burst_step_n_out = step_n;
    all_bytes_write_n_out = gw_n;
    byte_write_global_en_n_out = bwe_n;
    byte_write_select_n_out = bw_n;
    addr_out = a;
    // write data stands only in a write; a released bus inverts the last word each cycle, so the stale word shows every other cycle
    if (!gw_n || !bwe_n) begin
      {parity_lines_out, data_out} = wd;
    end else begin
      {parity_lines_out, data_out} = ~{parity_lines_out, data_out};
    end
    @(posedge sys_clk_in);
    #1;
  endtask
  // async pins and strap; the strap only moves while the bus idles between bursts
  task automatic set_pins(input logic oe_n, input logic slp, input logic order);
    output_enable_n_out = oe_n;
    sleep_request_out = slp;
    burst_order_out = order;
  endtask
endmodule

// ==== tb/tb_sbs_port.sv ====
// self-checking bench for the burst sram port and its write fifo
`timescale 1ns/10ps
module tb_sbs_port;
  import sbs_pkg::*;
  logic                  sys_clk_in, rst_n_in, run;  // clock, reset, clock enable
  logic [ADDR_W-1:0]     h_addr;                      // host address
  logic                  h_ctl_n, h_prc_n, h_cs_n, h_step_n, h_bwe_n, h_gw_n;
  logic [BYTES-1:0]      h_bw_n, h_par, port_par, bus_par;
  logic                  h_oe_n, h_sleep, h_order;
  logic [DATA_W-1:0]     h_data, port_data, bus_data;
  logic                  data_oe_out, sleep_active_out, write_busy_out;
  logic [BYTES+DATA_W-1:0] rd_word;                   // parity and data as read
  logic                  h_wr;                        // host drives write data this cycle
  int                    failures, checks, cycles;
  // the two-way pins: a host write owns the bus, else the port while it drives
  assign h_wr = !h_gw_n || !h_bwe_n;
  assign bus_data = (data_oe_out && !h_wr) ? port_data : h_data;
  assign bus_par = (data_oe_out && !h_wr) ? port_par : h_par;
  assign rd_word = {port_par, port_data};
  assign run = 1'b1;
  //////////////////////////////////////////////////////////////
  sbs_host_model sbs_host_model_inst (.sys_clk_in(sys_clk_in), .addr_out(h_addr),
    .controller_addr_strobe_n_out(h_ctl_n), .processor_addr_strobe_n_out(h_prc_n),
    .chip_select_primary_n_out(h_cs_n), .burst_step_n_out(h_step_n),
    .byte_write_select_n_out(h_bw_n), .byte_write_global_en_n_out(h_bwe_n),
    .all_bytes_write_n_out(h_gw_n), .output_enable_n_out(h_oe_n),
    .sleep_request_out(h_sleep), .burst_order_out(h_order), .data_out(h_data),
    .parity_lines_out(h_par));
  sbs_port sbs_port_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(run),
    .addr_in(h_addr), .controller_addr_strobe_n_in(h_ctl_n),
    .processor_addr_strobe_n_in(h_prc_n), .chip_select_primary_n_in(h_cs_n),
    .burst_step_n_in(h_step_n), .byte_write_select_n_in(h_bw_n),
    .byte_write_global_en_n_in(h_bwe_n), .all_bytes_write_n_in(h_gw_n),
    .output_enable_n_in(h_oe_n), .sleep_request_in(h_sleep), .burst_order_in(h_order),
    .data_in(bus_data), .parity_lines_in(bus_par), .data_out(port_data),
    .parity_lines_out(port_par), .data_oe_out(data_oe_out),
    .sleep_active_out(sleep_active_out), .write_busy_out(write_busy_out));
  //////////////////////////////////////////////////////////////
  // compare, count and report
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // bus shorthands: idle, all-bytes write, controller read, burst step
  task automatic idle(input int n);
    repeat (n) sbs_host_model_inst.bus_cycle(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, '0, '0);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [BYTES+DATA_W-1:0] wd);
    sbs_host_model_inst.bus_cycle(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 2'h3, a, wd);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    sbs_host_model_inst.bus_cycle(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, a, '0);
  endtask
  task automatic step();
    sbs_host_model_inst.bus_cycle(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 2'h3, '0, '0);
  endtask
  //////////////////////////////////////////////////////////////
  // scenarios: each drives the port and judges the answer
  task automatic t_write_read();
    wr(10'h010, 18'h2A55A);
    idle(3);
    rd(10'h00F);
    rd(10'h010);
    check("read word", rd_word, 18'h2A55A);
    check("read drive", data_oe_out, 1'b1);
    // lane 0 only, parity bit 0 set; lane 1 and its parity must stay
    sbs_host_model_inst.bus_cycle(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 2'h2, 10'h010, 18'h15B34);
    idle(3);
    rd(10'h010);
    check("byte write", rd_word, 18'h3A534);
    // both strobes with a global write: the processor read wins, nothing written
    sbs_host_model_inst.bus_cycle(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h3, 10'h010, 18'h0FFFF);
    check("priority read", rd_word, 18'h3A534);
    idle(3);
    rd(10'h010);
    check("priority kept", rd_word, 18'h3A534);
  endtask
  task automatic t_burst(input logic order);
    logic [1:0] lo;
    for (int i = 0; i < 4; i++) wr(10'h020 + i[9:0], 18'h00C00 + i[17:0]);
    check("write busy", write_busy_out, 1'b0);
    sbs_host_model_inst.set_pins(1'b0, 1'b0, order);
    idle(3);
    rd(10'h021);
    check("burst first", rd_word, 18'h00C01);
    for (int i = 1; i < 4; i++) begin
      lo = order ? (2'h1 ^ i[1:0]) : (2'h1 + i[1:0]);
      step();
      check("burst beat", rd_word, 18'h00C00 + {16'h0000, lo});
    end
  endtask
  task automatic t_deselect();
    sbs_host_model_inst.bus_cycle(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, 10'h010, '0);
    check("deselect drive", data_oe_out, 1'b0);
    rd(10'h010);
    check("first drive", data_oe_out, 1'b0);
    step();
    check("burst drive", data_oe_out, 1'b1);
  endtask
  task automatic t_oe_sleep();
    sbs_host_model_inst.set_pins(1'b1, 1'b0, 1'b1);
    idle(3);
    rd(10'h010);
    rd(10'h010);
    check("released drive", data_oe_out, 1'b0);
    sbs_host_model_inst.set_pins(1'b0, 1'b1, 1'b1);
    idle(4);
    check("sleep on", sleep_active_out, 1'b1);
    wr(10'h010, 18'h00000);
    sbs_host_model_inst.set_pins(1'b0, 1'b0, 1'b1);
    idle(4);
    check("sleep off", sleep_active_out, 1'b0);
    rd(10'h010);
    rd(10'h010);
    check("sleep kept", rd_word, 18'h3A534);
  endtask
  // back-to-back writes through the port's write fifo, then read every word back
  task automatic t_fifo();
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      wr(10'h030 + i[9:0], 18'h01200 + i[17:0]);
      check("fifo busy", write_busy_out, 1'b0);
    end
    idle(3);
    check("fifo drained", write_busy_out, 1'b0);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      rd(10'h030 + i[9:0]);
      check("fifo word", rd_word, 18'h01200 + i[17:0]);
      check("fifo drive", data_oe_out, 1'b1);
    end
  endtask
  //////////////////////////////////////////////////////////////
  // clock, hang guard and main sequence
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    {failures, checks, cycles} = '0;
    rst_n_in = 1'b0;
    repeat (5) @(posedge sys_clk_in);
    #1;
    rst_n_in = 1'b1;
    idle(3);
    t_write_read();
    t_burst(1'b0);
    t_burst(1'b1);
    t_deselect();
    t_oe_sleep();
    t_fifo();
    summarize();
  end
endmodule
